// *** rtl/dsc_id_decoder.sv ***
// Functional notes
// RULE1: 24-bit word, 8-bit opcode plus operands
// RULE2: exactly three opcodes take two words
// RULE3: second word upper 8 bits zero
// RULE4: lone second word executes as NOP
// RULE5: one cycle; two when taken/PC change
// RULE6: branches, tables, returns take 2-3 cycles; an untaken conditional branch takes one cycle here
// RULE7: taken skip: 2 or 3 cycles
// RULE8: two-word and double moves take two cycles
// RULE9: three register operands with modes
// RULE10: file address plus file-or-W0 destination
// RULE11: file address spans 0x0000 to 0x1fff
// RULE12: bit select literal or from base
// RULE13: unsigned ten-bit literal byte/word limits
// RULE14: 23-bit address literal LSB zero
// RULE15: signed ten-bit literal, two's complement
// RULE16: MAC operands: accumulator, pair, prefetches, writeback
// RULE17: writeback W13 or [W13] plus two
// RULE18: byte, word, double size; shadow select
// RULE19: integer and accumulator status flags held
// RULE20: first word consumes next word as extension
`timescale 1ns/1ps
`include "dsc_id_cfg.svh"

module dsc_id_decoder (
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   fetch_valid,
  input  wire logic [23:0]            fetch_word,
  input  wire logic                   cond_true,
  output logic                        fetch_ready,
  output logic                        issue_valid,
  output dsc_id_pkg::dsc_issue_t      issue,
  output logic                        slot_nop,
  input  wire logic                   flag_upd_valid,
  input  wire dsc_id_pkg::dsc_flags_t flag_upd,
  output dsc_id_pkg::dsc_flags_t      flags
);

  // ---------------------------------------------------------------
  // Word decoder
  // ---------------------------------------------------------------
  // Fields cut in parallel; class says which count
  function automatic dsc_id_pkg::dsc_issue_t decode_word(
    input logic [23:0] w,
    input logic        cond
  );
    dsc_id_pkg::dsc_issue_t d;
    logic [7:0]             op;
    d  = '0;
    op = w[`DSC_OPC_MSB:`DSC_OPC_LSB]; // RULE1
    d.opcode = op;
    case (op[7:4])
      `DSC_GRP_CTRL:   d.cls = dsc_id_pkg::CLS_CTRL;
      `DSC_GRP_WORKING_REG_ZERO_ALIAS_A,
      `DSC_GRP_WORKING_REG_ZERO_ALIAS_B,
      `DSC_GRP_WORKING_REG_ZERO_ALIAS_C: d.cls = dsc_id_pkg::CLS_WORKING_REG_ZERO_ALIAS;
      `DSC_GRP_BRANCH: d.cls = dsc_id_pkg::CLS_BRANCH;
      `DSC_GRP_LIT_U:  d.cls = dsc_id_pkg::CLS_LIT_U;
      `DSC_GRP_LIT_S:  d.cls = dsc_id_pkg::CLS_LIT_S;
      `DSC_GRP_BIT:    d.cls = dsc_id_pkg::CLS_BIT;
      `DSC_GRP_SKIP:   d.cls = dsc_id_pkg::CLS_SKIP;
      `DSC_GRP_FILE:   d.cls = dsc_id_pkg::CLS_FILE;
      `DSC_GRP_MOVE:   d.cls = dsc_id_pkg::CLS_MOVE;
      `DSC_GRP_TABLE:  d.cls = dsc_id_pkg::CLS_TABLE;
      `DSC_GRP_MAC:    d.cls = dsc_id_pkg::CLS_MAC;
      default:         d.cls = dsc_id_pkg::CLS_OTHER;
    endcase
    // Only these three opcodes span two words
    d.two_word = (op == `DSC_OP_GOTO) || (op == `DSC_OP_CALL)
               || (op == `DSC_OP_DO); // RULE2
    // Lone extension word has opcode zero: NOP
    d.nop = (op == `DSC_OP_NOP); // RULE4
    // Size from opcode low bits; 11 means word
    case (op[1:0])
      2'b01:   d.size = dsc_id_pkg::SZ_BYTE; // RULE18
      2'b10:   d.size = dsc_id_pkg::SZ_DBL;
      default: d.size = dsc_id_pkg::SZ_WORD;
    endcase
    d.shadow = (d.cls == dsc_id_pkg::CLS_CTRL) & w[15]; // RULE18
    // Three register operands
    d.base_source_reg   = w[15:12]; // RULE9
    d.dst_mode          = w[11:10];
    d.destination_reg   = w[9:6];
    d.src_mode          = w[5:4];
    d.second_source_reg = w[3:0];
    // File operand: 13 bits span 0x0000..0x1fff
    d.file_addr  = w[12:0]; // RULE10 RULE11
    d.file_to_w0 = w[13]; // RULE10
    // Bit position: literal or from base register
    d.bit_select_field = w[15:12]; // RULE12
    d.bit_indirect     = w[11];
    d.bit_in_file      = op[0];
    if (d.cls == dsc_id_pkg::CLS_BIT) begin
      d.base_source_reg = w[7:4]; // RULE12
      d.file_addr       = {2'b00, w[10:0]};
    end
    // Literal operands
    d.unsigned_literal_ten = w[13:4]; // RULE13
    d.signed_literal_ten   = {{6{w[13]}}, w[13:4]}; // RULE15
    if ((d.cls == dsc_id_pkg::CLS_LIT_U) || (d.cls == dsc_id_pkg::CLS_LIT_S)) begin
      d.destination_reg = w[3:0];
    end
    d.lit_range_err = (d.cls == dsc_id_pkg::CLS_LIT_U) && (d.size == dsc_id_pkg::SZ_BYTE)
                    && (w[13:4] > `DSC_BYTE_LIT_MAX); // RULE13
    // Program address low half; bit 0 forced low
    d.unsigned_literal_twentythree = {7'h00, w[15:1], 1'b0}; // RULE14
    d.addr_lsb_err = ((op == `DSC_OP_GOTO) || (op == `DSC_OP_CALL)) && w[0]; // RULE14
    // MAC operands
    d.acc_b      = op[0]; // RULE16
    d.mul_pair   = w[15:13];
    d.x_prefetch = w[12:9];
    d.x_dest     = w[8:7];
    d.y_prefetch = w[6:3];
    d.y_dest     = w[2:1];
    if (!op[1]) begin
      d.accum_writeback_dest = dsc_id_pkg::AWB_NONE;
    end else if (w[0]) begin
      d.accum_writeback_dest = dsc_id_pkg::AWB_POSTINC; // RULE17
    end else begin
      d.accum_writeback_dest = dsc_id_pkg::AWB_DIRECT; // RULE17
    end
    // Cycle cost
    d.cycles = `DSC_CYC_ONE; // RULE5
    if (d.two_word || (d.cls == dsc_id_pkg::CLS_TABLE)) begin
      d.cycles = `DSC_CYC_TWO; // RULE6 RULE8
    end else if ((d.cls == dsc_id_pkg::CLS_MOVE) && (d.size == dsc_id_pkg::SZ_DBL)) begin
      d.cycles = `DSC_CYC_TWO; // RULE8
    end else if ((op == `DSC_OP_RETURN) || (op == `DSC_OP_INT_RETURN)) begin
      d.cycles = `DSC_CYC_THREE; // RULE6
    end else if ((op == `DSC_OP_CALL_IND) || (op == `DSC_OP_GOTO_IND)) begin
      d.cycles = `DSC_CYC_TWO; // RULE6
    end else if (d.cls == dsc_id_pkg::CLS_BRANCH) begin
      if ((op[3:1] == `DSC_BR_UNCOND) || cond) begin
        d.cycles = `DSC_CYC_TWO; // RULE5 RULE6
      end
    end else if ((d.cls == dsc_id_pkg::CLS_SKIP) && cond) begin
      d.cycles = `DSC_CYC_TWO; // RULE7
    end
    return d;
  endfunction : decode_word

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  function automatic logic [31:0] read_reg(
    input dsc_id_pkg::dsc_state_t st,
    input logic [7:0]             a
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `DSC_REG_CTRL:   r = {31'h0000_0000, st.enable};
      `DSC_REG_STATUS: r = {22'h00_0000, st.fsm, st.last_cycles, st.err};
      `DSC_REG_FLAGS:  r = {23'h00_0000, st.flags};
      `DSC_REG_LAST:   r = {20'h0_0000, st.last_cls, st.last_opcode};
      `DSC_REG_COUNT:  r = st.issue_count;
      default:         r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_reg

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dsc_id_pkg::dsc_state_t state_reg;
  dsc_id_pkg::dsc_state_t state_next;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Software writes first so hardware events win
  always_comb begin
    dsc_id_pkg::dsc_issue_t d;
    logic                   accept;
    d          = decode_word(fetch_word, cond_true);
    accept     = fetch_valid & state_reg.fetch_ready;
    state_next = state_reg;
    state_next.issue_valid = 1'b0;
    state_next.slot_nop    = 1'b0;

    // Data phase of a bus write
    if (state_reg.dph_wr) begin
      case (state_reg.dph_addr)
        `DSC_REG_CTRL:   state_next.enable = hwdata[0];
        `DSC_REG_STATUS: state_next.err    = state_reg.err & ~hwdata[2:0];
        `DSC_REG_FLAGS:  state_next.flags  = dsc_id_pkg::dsc_flags_t'(hwdata[8:0]);
        default:         state_next.enable = state_reg.enable;
      endcase
    end

    // Issue sequencer
    case (state_reg.fsm)
      dsc_id_pkg::ST_RUN: begin
        if (accept) begin
          if (d.two_word) begin
            state_next.pend = d; // RULE20
            state_next.fsm  = dsc_id_pkg::ST_EXT;
          end else begin
            state_next.issue       = d;
            state_next.issue_valid = 1'b1;
            state_next.last_cycles = d.cycles;
            if ((d.cls == dsc_id_pkg::CLS_SKIP) && cond_true) begin
              state_next.fsm = dsc_id_pkg::ST_SKIP; // RULE7
            end else if (d.cycles != `DSC_CYC_ONE) begin
              state_next.stall_cnt = d.cycles - `DSC_CYC_ONE; // RULE5 RULE6
              state_next.fsm       = dsc_id_pkg::ST_STALL;
            end
          end
        end
      end
      dsc_id_pkg::ST_EXT: begin
        // Next word is operand only, never issued
        if (accept) begin
          state_next.issue          = state_reg.pend; // RULE20
          state_next.issue.ext_word = fetch_word;
          state_next.issue.ext_err  = |fetch_word[`DSC_OPC_MSB:`DSC_OPC_LSB]; // RULE3
          state_next.issue.unsigned_literal_twentythree[22:16] = fetch_word[6:0]; // RULE14
          state_next.issue_valid    = 1'b1;
          state_next.last_cycles    = `DSC_CYC_TWO; // RULE8
          state_next.fsm            = dsc_id_pkg::ST_RUN;
        end
      end
      dsc_id_pkg::ST_STALL: begin
        // Extra cycles run as NOPs with fetch held off
        state_next.slot_nop  = 1'b1; // RULE5
        state_next.stall_cnt = state_reg.stall_cnt - `DSC_CYC_ONE;
        if (state_reg.stall_cnt == `DSC_CYC_ONE) begin
          state_next.fsm = dsc_id_pkg::ST_RUN;
        end
      end
      dsc_id_pkg::ST_SKIP: begin
        // Skipped word squashed; two-word costs one more
        if (accept) begin
          state_next.slot_nop = 1'b1; // RULE7
          if (d.two_word) begin
            state_next.last_cycles = `DSC_CYC_THREE; // RULE7
            state_next.fsm         = dsc_id_pkg::ST_SKIP_EXT;
          end else begin
            state_next.fsm = dsc_id_pkg::ST_RUN;
          end
        end
      end
      dsc_id_pkg::ST_SKIP_EXT: begin
        if (accept) begin
          state_next.slot_nop = 1'b1; // RULE7
          state_next.fsm      = dsc_id_pkg::ST_RUN;
        end
      end
      default: begin
        state_next.fsm = dsc_id_pkg::ST_RUN;
      end
    endcase

    // Issue bookkeeping; sticky errors set over clears
    if (state_next.issue_valid) begin
      state_next.issue_count = state_reg.issue_count + 32'h0000_0001;
      state_next.last_opcode = state_next.issue.opcode;
      state_next.last_cls    = state_next.issue.cls;
      state_next.err         = state_next.err | {state_next.issue.addr_lsb_err,
                                                 state_next.issue.ext_err,
                                                 state_next.issue.lit_range_err};
    end

    // Flag update beats software write
    if (flag_upd_valid) begin
      state_next.flags = flag_upd; // RULE19
    end

    // Ready when enabled and not stalling
    state_next.fetch_ready = state_next.enable
                           & (state_next.fsm != dsc_id_pkg::ST_STALL);

    // Address phase; read sees this cycle's updates
    state_next.dph_wr = 1'b0;
    if (hsel & htrans[1] & hready) begin
      state_next.dph_wr   = hwrite;
      state_next.dph_addr = haddr[7:0];
      if (!hwrite) begin
        state_next.hrdata = read_reg(state_next, haddr[7:0]);
      end
    end
    state_next.hreadyout = 1'b1;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg             <= '0;
      state_reg.fsm         <= dsc_id_pkg::ST_RUN;
      state_reg.enable      <= `DSC_CTRL_EN_RST;
      state_reg.fetch_ready <= `DSC_CTRL_EN_RST;
      state_reg.hreadyout   <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs from flops; hresp tied low
  // ---------------------------------------------------------------
  assign hrdata      = state_reg.hrdata;
  assign hreadyout   = state_reg.hreadyout;
  assign hresp       = 1'b0; // Always OKAY
  assign fetch_ready = state_reg.fetch_ready;
  assign issue_valid = state_reg.issue_valid;
  assign issue       = state_reg.issue;
  assign slot_nop    = state_reg.slot_nop;
  assign flags       = state_reg.flags;

endmodule : dsc_id_decoder

// *** include/dsc_id_cfg.svh ***
`ifndef DSC_ID_CFG_SVH
`define DSC_ID_CFG_SVH

// ---------------------------------------------------------------
// Program word layout
// ---------------------------------------------------------------
`define DSC_OPC_MSB       23
`define DSC_OPC_LSB       16
`define DSC_BYTE_LIT_MAX  10'h0ff

// ---------------------------------------------------------------
// Opcode groups (opcode upper nibble)
// ---------------------------------------------------------------
`define DSC_GRP_CTRL      4'h0
`define DSC_GRP_WORKING_REG_ZERO_ALIAS_A    4'h1
`define DSC_GRP_WORKING_REG_ZERO_ALIAS_B    4'h2
`define DSC_GRP_BRANCH    4'h3
`define DSC_GRP_WORKING_REG_ZERO_ALIAS_C    4'h4
`define DSC_GRP_LIT_U     4'h5
`define DSC_GRP_LIT_S     4'h6
`define DSC_GRP_BIT       4'h7
`define DSC_GRP_SKIP      4'h8
`define DSC_GRP_FILE      4'h9
`define DSC_GRP_MOVE      4'ha
`define DSC_GRP_TABLE     4'hb
`define DSC_GRP_MAC       4'hc

// ---------------------------------------------------------------
// Specific opcodes
// ---------------------------------------------------------------
`define DSC_OP_NOP        8'h00
`define DSC_OP_CALL_IND   8'h01
`define DSC_OP_CALL       8'h02
`define DSC_OP_GOTO       8'h04
`define DSC_OP_GOTO_IND   8'h05
`define DSC_OP_RETURN     8'h06
`define DSC_OP_INT_RETURN 8'h07
`define DSC_OP_DO         8'h08
`define DSC_BR_UNCOND     3'h7

// ---------------------------------------------------------------
// Instruction cycle counts
// ---------------------------------------------------------------
`define DSC_CYC_ONE       2'd1
`define DSC_CYC_TWO       2'd2
`define DSC_CYC_THREE     2'd3

// ---------------------------------------------------------------
// Register offsets and resets
// ---------------------------------------------------------------
`define DSC_REG_CTRL      8'h00
`define DSC_REG_STATUS    8'h04
`define DSC_REG_FLAGS     8'h08
`define DSC_REG_LAST      8'h0c
`define DSC_REG_COUNT     8'h10
`define DSC_CTRL_EN_RST   1'b1

`endif

// *** include/dsc_id_pkg.sv ***
package dsc_id_pkg;

  // -------------------------------------------------------------
  // Enumerations
  // -------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN      = 5'b00001,
    ST_EXT      = 5'b00010,
    ST_STALL    = 5'b00100,
    ST_SKIP     = 5'b01000,
    ST_SKIP_EXT = 5'b10000
  } dsc_fsm_t;

  typedef enum logic [3:0] {
    CLS_CTRL   = 4'h0,
    CLS_WORKING_REG_ZERO_ALIAS   = 4'h1,
    CLS_BRANCH = 4'h2,
    CLS_LIT_U  = 4'h3,
    CLS_LIT_S  = 4'h4,
    CLS_BIT    = 4'h5,
    CLS_SKIP   = 4'h6,
    CLS_FILE   = 4'h7,
    CLS_MOVE   = 4'h8,
    CLS_TABLE  = 4'h9,
    CLS_MAC    = 4'ha,
    CLS_OTHER  = 4'hf
  } dsc_cls_t;

  typedef enum logic [1:0] {
    SZ_WORD = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_DBL  = 2'b10
  } dsc_size_t;

  typedef enum logic [1:0] {
    AWB_NONE    = 2'b00,
    AWB_DIRECT  = 2'b01,
    AWB_POSTINC = 2'b10
  } dsc_awb_t;

  // -------------------------------------------------------------
  // Carriers
  // -------------------------------------------------------------
  typedef struct packed {
    logic c;
    logic digit_carry_flag;
    logic n;
    logic overflow_flag;
    logic z;
    logic accum_a_overflow_flag;
    logic accum_b_overflow_flag;
    logic accum_a_saturate_flag;
    logic accum_b_saturate_flag;
  } dsc_flags_t;

  typedef struct packed {
    logic [7:0]  opcode;
    dsc_cls_t    cls;
    logic        two_word;
    logic        nop;
    logic [1:0]  cycles;
    dsc_size_t   size;
    logic        shadow;
    logic [3:0]  base_source_reg;
    logic [3:0]  second_source_reg;
    logic [1:0]  src_mode;
    logic [3:0]  destination_reg;
    logic [1:0]  dst_mode;
    logic [12:0] file_addr;
    logic        file_to_w0;
    logic [3:0]  bit_select_field;
    logic        bit_indirect;
    logic        bit_in_file;
    logic [9:0]  unsigned_literal_ten;
    logic [15:0] signed_literal_ten;
    logic [22:0] unsigned_literal_twentythree;
    logic        acc_b;
    logic [2:0]  mul_pair;
    logic [3:0]  x_prefetch;
    logic [1:0]  x_dest;
    logic [3:0]  y_prefetch;
    logic [1:0]  y_dest;
    dsc_awb_t    accum_writeback_dest;
    logic [23:0] ext_word;
    logic        lit_range_err;
    logic        ext_err;
    logic        addr_lsb_err;
  } dsc_issue_t;

  typedef struct packed {
    dsc_fsm_t    fsm;
    dsc_issue_t  pend;
    dsc_issue_t  issue;
    logic        issue_valid;
    logic        slot_nop;
    logic        fetch_ready;
    logic [1:0]  stall_cnt;
    logic        enable;
    dsc_flags_t  flags;
    logic [2:0]  err;
    logic [1:0]  last_cycles;
    logic [7:0]  last_opcode;
    dsc_cls_t    last_cls;
    logic [31:0] issue_count;
    logic        dph_wr;
    logic [7:0]  dph_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
  } dsc_state_t;

endpackage : dsc_id_pkg

// *** bench/dsc_id_checker_asserts.sv ***
`timescale 1ns/1ps
module dsc_id_checker (
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  input wire logic [23:0]            fetch_word,
  input wire logic                   fetch_ready,
  input wire logic                   issue_valid,
  input wire dsc_id_pkg::dsc_issue_t issue,
  input wire logic                   slot_nop,
  input wire logic                   flag_upd_valid,
  input wire dsc_id_pkg::dsc_flags_t flag_upd,
  input wire dsc_id_pkg::dsc_flags_t flags
);
  // ---------------------------------------------------------------
  // Issue and flag checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_opcode_field: assert property (
    issue_valid && !issue.two_word |-> issue.opcode == $past(fetch_word[23:16]))
    else $error("issued opcode differs from taken word");
  chk_two_word_set: assert property (
    issue_valid && issue.two_word |-> issue.opcode inside {8'h02, 8'h04, 8'h08})
    else $error("two-word flag on wrong opcode");
  chk_ext_upper: assert property (
    issue_valid && issue.two_word |-> issue.ext_word == $past(fetch_word)
      && issue.ext_err == (issue.ext_word[23:16] != 8'h00))
    else $error("extension word or its error flag wrong");
  chk_lone_nop: assert property (
    issue_valid && issue.opcode == 8'h00 && !issue.two_word |-> issue.nop)
    else $error("lone second word not a nop");
  chk_stall_slots: assert property (
    issue_valid && issue.cycles == 2'd3 |-> !fetch_ready ##1 (slot_nop && !issue_valid)[*2])
    else $error("three-cycle issue without two nop slots");
  chk_two_cycles: assert property (
    issue_valid && issue.two_word |-> issue.cycles == 2'd2)
    else $error("two-word instruction not two cycles");
  chk_byte_limit: assert property (
    issue_valid && issue.cls == dsc_id_pkg::CLS_LIT_U && issue.size == dsc_id_pkg::SZ_BYTE
      |-> issue.lit_range_err == (issue.unsigned_literal_ten > 10'd255))
    else $error("byte literal limit flag wrong");
  chk_unsigned_literal_twentythree_lsb: assert property (
    issue_valid |-> !issue.unsigned_literal_twentythree[0])
    else $error("address literal lsb set");
  chk_signed_ext: assert property (
    issue_valid && issue.cls == dsc_id_pkg::CLS_LIT_S |-> issue.signed_literal_ten ==
      {{6{issue.unsigned_literal_ten[9]}}, issue.unsigned_literal_ten})
    else $error("signed literal not sign extended");
  chk_flag_load: assert property (
    flag_upd_valid |=> flags == $past(flag_upd))
    else $error("flag update not held");
endmodule : dsc_id_checker

bind dsc_id_decoder dsc_id_checker dsc_id_checker_i (.core_clk, .rst_b, .fetch_word,
  .fetch_ready, .issue_valid, .issue, .slot_nop, .flag_upd_valid, .flag_upd, .flags);

// *** bench/dsc_id_progmem.sv ***
`timescale 1ns/1ps
module dsc_id_progmem (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        fetch_ready,
  input  wire logic        slow,
  output logic             fetch_valid,
  output logic [23:0]      fetch_word,
  output logic             cond_true
);
  logic [24:0] mem [0:63];
  logic [5:0]  rd;
  logic [5:0]  wr;
  logic [24:0] last;
  logic        gap;

  initial wr = 6'h00;

  // One word per edge; no two loads share a time step
  task put(input logic [23:0] w, input logic c);
    @(posedge core_clk);
    mem[wr] <= {c, w};
    wr <= wr + 6'h01;
  endtask : put

  // Idle bus shows inverted last word
  assign fetch_valid = (rd != wr) && !gap;
  assign {cond_true, fetch_word} = fetch_valid ? mem[rd] : ~last;

  // Advance on accept; slow mode gaps every other cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd   <= 6'h00;
      gap  <= 1'b0;
      last <= 25'h0000000;
    end else begin
      if (fetch_valid && fetch_ready) rd <= rd + 6'h01;
      if (fetch_valid) last <= mem[rd];
      gap <= slow && !gap;
    end
  end
endmodule : dsc_id_progmem

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic                   core_clk, rst_b, hsel, hwrite, hreadyout, hresp, slow;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic                   fetch_valid, cond_true, fetch_ready, issue_valid, slot_nop;
  logic [23:0]            fetch_word;
  logic                   flag_upd_valid;
  dsc_id_pkg::dsc_flags_t flag_upd, flags;
  dsc_id_pkg::dsc_issue_t issue, cur, iss_q[$];
  int                     err_total, n_tests, nops;
  localparam logic [23:0] CW [9] = '{24'h060000, 24'h070000, 24'h3e0000, 24'h300000,
    24'h300000, 24'hb00000, 24'ha20000, 24'h010000, 24'h050000};
  localparam int          CY [9] = '{3, 3, 2, 2, 1, 2, 2, 2, 2};

  dsc_id_decoder dsc_id_decoder_i (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .fetch_valid,
    .fetch_word, .cond_true, .fetch_ready, .issue_valid, .issue, .slot_nop,
    .flag_upd_valid, .flag_upd, .flags);
  dsc_id_progmem dsc_id_progmem_i (.core_clk, .rst_b, .fetch_ready, .slow, .fetch_valid,
    .fetch_word, .cond_true);

  // ---------------------------------------------------------------
  // Clock, monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Log issues and nop slots
  always @(posedge core_clk) begin
    if (rst_b === 1'b1 && issue_valid === 1'b1) iss_q.push_back(issue);
    if (rst_b === 1'b1 && slot_nop === 1'b1) nops++;
  end

  // Run is under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // Single transfer; read data taken at data-phase edge
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task feed(input logic [23:0] w, input logic c);
    dsc_id_progmem_i.put(w, c);
  endtask : feed

  // Empty the memory, then let stalls finish
  task drain();
    for (int i = 0; i < 200 && dsc_id_progmem_i.rd != dsc_id_progmem_i.wr; i++)
      @(posedge core_clk);
    repeat (6) @(posedge core_clk);
  endtask : drain

  task pop();
    if (iss_q.size() == 0) begin
      cur = '0;
      chk(32'h0, 32'h1);
    end else cur = iss_q.pop_front();
  endtask : pop

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_regs();
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h20);
    ahb(1'b0, 32'h40, 32'h0);
    chk(rd, 32'h0);
    chk({hreadyout, hresp}, 32'h2);
    ahb(1'b1, 32'h8, 32'h0f0);
    @(negedge core_clk);
    chk(flags, 32'h0f0);
  endtask : t_regs

  task t_fields();
    feed(24'h12a5c3, 1'b0);
    feed(24'h903fff, 1'b0);
    feed(24'h71f8a0, 1'b0);
    drain();
    pop();
    chk(cur.base_source_reg, 32'ha);
    chk(cur.destination_reg, 32'h7);
    chk(cur.second_source_reg, 32'h3);
    pop();
    chk(cur.file_addr, 32'h1fff);
    chk(cur.file_to_w0, 32'h1);
    pop();
    chk(cur.bit_select_field, 32'hf);
    chk(cur.bit_indirect, 32'h1);
  endtask : t_fields

  task t_cycles();
    int n0;
    n0 = nops;
    for (int i = 0; i < 9; i++) feed(CW[i], i == 3);
    drain();
    for (int i = 0; i < 9; i++) begin
      pop();
      chk(cur.cycles, CY[i]);
    end
    chk(nops - n0, 32'd10);
  endtask : t_cycles

  // Slow memory splits pairs
  task t_twoword();
    int n0;
    n0 = nops;
    slow <= 1'b1;
    feed(24'h021234, 1'b0);
    feed(24'h000045, 1'b0);
    feed(24'h040001, 1'b0);
    feed(24'h120000, 1'b0);
    feed(24'h080000, 1'b0);
    feed(24'h000000, 1'b0);
    feed(24'h000045, 1'b0);
    drain();
    slow <= 1'b0;
    pop();
    chk(cur.unsigned_literal_twentythree, 32'h451234);
    chk(cur.ext_err, 32'h0);
    pop();
    chk(cur.addr_lsb_err, 32'h1);
    pop();
    chk(cur.two_word, 32'h1);
    pop();
    chk(cur.nop, 32'h1);
    chk(nops - n0, 32'h0);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd[2:1], 32'h3);
    ahb(1'b1, 32'h4, 32'h7);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd[2:0], 32'h0);
  endtask : t_twoword

  task t_skip();
    int n0;
    n0 = nops;
    feed(24'h800000, 1'b1);
    feed(24'h040000, 1'b0);
    feed(24'h000010, 1'b0);
    drain();
    pop();
    chk(cur.cycles, 32'h2);
    chk(nops - n0, 32'h2);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd[4:3], 32'h3);
    feed(24'h800000, 1'b1);
    feed(24'h120000, 1'b0);
    feed(24'h500000, 1'b0);
    drain();
    pop();
    pop();
    chk(cur.opcode, 32'h50);
  endtask : t_skip

  task t_lit();
    feed(24'h511ff0, 1'b0);
    feed(24'h622000, 1'b0);
    feed(24'h523ff0, 1'b0);
    drain();
    pop();
    chk(cur.size, dsc_id_pkg::SZ_BYTE);
    chk(cur.lit_range_err, 32'h1);
    pop();
    chk(cur.signed_literal_ten, 32'hfe00);
    pop();
    chk(cur.size, dsc_id_pkg::SZ_DBL);
    chk(cur.unsigned_literal_ten, 32'h3ff);
  endtask : t_lit

  task t_mac();
    feed(24'hc3e001, 1'b0);
    feed(24'hc20000, 1'b0);
    drain();
    pop();
    chk(cur.acc_b, 32'h1);
    chk(cur.mul_pair, 32'h7);
    chk(cur.accum_writeback_dest, dsc_id_pkg::AWB_POSTINC);
    pop();
    chk(cur.accum_writeback_dest, dsc_id_pkg::AWB_DIRECT);
  endtask : t_mac

  task t_flags();
    @(posedge core_clk);
    flag_upd_valid <= 1'b1;
    flag_upd <= 9'h1a5;
    @(posedge core_clk);
    flag_upd_valid <= 1'b0;
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h1a5);
  endtask : t_flags

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, slow, flag_upd_valid} = '0;
    hsize = 3'h2;
    flag_upd = '0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_fields();
    t_cycles();
    t_twoword();
    t_skip();
    t_lit();
    t_mac();
    t_flags();
    print_verdict();
  end
endmodule : tb
